// file: rtl/lio_pkg.sv
// Package for the labeler I/O supervision block: modes, layouts, counts.
// Assumes a 40 MHz system clock; all field inputs arrive active low.
package lio_pkg;

	localparam int CLK_HZ = 40000000;
	localparam int SPACING_MIN_MM = 10;
	localparam int SPACING_MAX_MM = 100;
	localparam logic [6:0] SPACING_RST = 7'h32;
	localparam int TIMER_W = 32;
	localparam logic [31:0] TIMER_MAX = 32'hFFFFFFFF;
	localparam int COUNT_W = 32;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		LIO_SPD_FIXED = 2'b00,
		LIO_SPD_MEASURE = 2'b01,
		LIO_SPD_INCR = 2'b10
	} lio_speed_mode_e;

	typedef enum logic [1:0] {
		LIO_MS_IDLE = 2'b00,
		LIO_MS_TIMING = 2'b01,
		LIO_MS_DONE = 2'b10
	} lio_meas_state_e;

	// Driver supervision lines as seen after synchronisation
	typedef struct packed {
		logic phase_short;
		logic overtemp;
		logic overvoltage;
		logic undervoltage;
	} lio_fault_s;

	// Register offsets on the AHB-Lite slave
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_SPACING = 8'h08;
	localparam logic [7:0] REG_INTERVAL = 8'h0C;
	localparam logic [7:0] REG_PULSES = 8'h10;
	localparam logic [7:0] REG_GOODS = 8'h14;
	localparam logic [7:0] REG_MSG = 8'h18;

	// CTRL fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_EXT_CNT = 2;
	localparam int CTRL_NONSTOP = 3;
	localparam int CTRL_DISPENSE = 4;
	localparam int CTRL_RUNKEY = 5;
	localparam int CTRL_CONFIRM = 6;
	localparam int CTRL_WARN_SET = 7;
	localparam int CTRL_ERR_SET = 8;
	localparam int CTRL_ARM_MEAS = 9;

	// STATUS fields
	localparam int ST_FAULT_LSB = 0;
	localparam int ST_HEALTHY = 4;
	localparam int ST_RUN = 5;
	localparam int ST_BUSY = 6;
	localparam int ST_WARN = 7;
	localparam int ST_ERR = 8;
	localparam int ST_MEAS_DONE = 9;
	localparam int ST_SPACING_BAD = 10;
	localparam int ST_LABEL_OK = 11;
	localparam int ST_MOTOR_EN = 12;

endpackage

// file: rtl/lio_sync.sv
// Two-stage synchroniser with active-high output and edge pulse.
// Assumes an active-low field line; the edge is inactive-to-active.
`timescale 1ns/1ps
`default_nettype none
module lio_sync (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic line_n,
	output logic active,
	output logic rise
);
	logic meta_r, meta_nxt;
	logic sync_r, sync_nxt;
	logic prev_r, prev_nxt;

	always_comb begin
		meta_nxt = meta_r;
		sync_nxt = sync_r;
		prev_nxt = prev_r;
		if (ce) begin
			meta_nxt = ~line_n;
			sync_nxt = meta_r;
			prev_nxt = sync_r;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
			prev_r <= prev_nxt;
		end
	end

	assign active = sync_r;
	assign rise = sync_r & ~prev_r & ce;
endmodule
`default_nettype wire

// file: rtl/lio_ahb.sv
// AHB-Lite slave front end: latches the address phase, yields strobes.
// Assumes single word transfers, OKAY response; a read right after a
// write waits one cycle, every other transfer has zero wait states.
`timescale 1ns/1ps
`default_nettype none
module lio_ahb (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] addr
);
	logic wpend_r, wpend_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic take;
	logic stall;

	// A read right behind a write would steal addr from the pending write;
	// one wait state lets the write land on its own address first
	assign stall = wpend_r & hsel & htrans[1] & ~hwrite;
	// Only NONSEQ/SEQ of a whole word are taken
	assign take = hsel & hready & htrans[1] & (hsize == 3'h2) & ce &
		~stall;

	always_comb begin
		wpend_nxt = wpend_r;
		addr_nxt = addr_r;
		if (ce) begin
			wpend_nxt = take & hwrite;
			if (take) begin
				addr_nxt = haddr[7:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wpend_r <= 1'b0;
			addr_r <= 8'h00;
		end else begin
			wpend_r <= wpend_nxt;
			addr_r <= addr_nxt;
		end
	end

	// Reads decode on the address phase so data is ready next cycle
	assign rd_en = take & ~hwrite;
	assign wr_en = wpend_r & ce;
	assign addr = rd_en ? haddr[7:0] : addr_r;
	assign hreadyout = ~stall;
	assign hresp = 1'b0;
endmodule
`default_nettype wire

// file: rtl/lio_top.sv
// Labeler I/O supervision: driver faults, scanners, counter, run/stop.
// Assumes field lines active low, power-on reset only on hresetn.
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RL1 - Separate flag per driver fault condition
// RL2 - Healthy only when fault-free, supply good
// RL3 - Any fault de-energises motor, drops healthy
// RL4 - Faults latch; cleared by power cycle only
// RL5 - Motion output asserted exactly while dispensing
// RL6 - Peripheral busy inhibits labelling, posts message
// RL7 - Sensors pull low active, release inactive
// RL8 - Goods scanner detects goods; speed scanner measures
// RL9 - Fixed mode ignores speed scanner entirely
// RL10 - Spacing accepted only within 10..100 mm
// RL11 - Time speed edge to goods edge
// RL12 - Incremental mode counts encoder pulses
// RL13 - Count input counts in nonstop or external
// RL14 - External stop edge toggles run/stop
// RL15 - Status relays follow current run mode
// RL16 - Toggle never resets or pauses counter
// RL17 - Toggle leaves pending messages active
// RL18 - Field inputs pass two-stage synchroniser
// RL19 - Toggle only on inactive-to-active edge
// RL20 - Messages clear after cause gone plus confirm
module lio_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic drv_short_n,
	input wire logic drv_overtemp_n,
	input wire logic drv_overvolt_n,
	input wire logic drv_undervolt_n,
	input wire logic drv_supply_ok_n,
	input wire logic speed_scanner_in_n,
	input wire logic goods_scanner_in_n,
	input wire logic goods_count_in_n,
	input wire logic ext_stop_in_n,
	input wire logic periph_ready_in_n,
	output logic driver_healthy_flag,
	output logic phase_short_flag,
	output logic overtemp_flag,
	output logic overvoltage_flag,
	output logic undervoltage_flag,
	output logic motor_enable,
	output logic motion_out,
	output logic run_relay_out,
	output logic warning_relay_out,
	output logic error_relay_out
);
	// Synchronised field inputs
	logic [9:0] line_n, act, rise;
	lio_pkg::lio_fault_s flt_now;
	logic supply_ok, speed_rise, goods_rise;
	logic count_rise, stop_rise, busy;

	assign line_n = {periph_ready_in_n, ext_stop_in_n, goods_count_in_n,
		goods_scanner_in_n, speed_scanner_in_n, drv_supply_ok_n,
		drv_undervolt_n, drv_overvolt_n, drv_overtemp_n, drv_short_n};

	// Fault, supply and busy lines are used as levels, scanner, count and stop lines as edges
	genvar gi;
	generate
		for (gi = 0; gi < 10; gi++) begin : g_sync
			lio_sync u_sync (
				.hclk(hclk),
				.hresetn(hresetn),
				.ce(ce),
				.line_n(line_n[gi]), // RL7 RL18
				.active(act[gi]),
				.rise(rise[gi])
			);
		end
	endgenerate

	assign flt_now = '{phase_short: act[0], overtemp: act[1],
		overvoltage: act[2], undervoltage: act[3]};
	assign supply_ok = act[4];
	assign speed_rise = rise[5];
	assign goods_rise = rise[6];
	assign count_rise = rise[7];
	assign stop_rise = rise[8]; // RL19
	assign busy = act[9];

	// Bus front end
	logic wr_en, rd_en;
	logic [7:0] addr;
	lio_ahb u_ahb (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.addr(addr)
	);

	function automatic logic [31:0] sat_inc(input logic [31:0] v);
		sat_inc = (v == lio_pkg::TIMER_MAX) ? v : v + 32'h00000001;
	endfunction

	// Strobe bits act only in the cycle a CTRL write lands
	function automatic logic ctrl_strobe(input logic wr,
		input logic [31:0] d, input int pos);
		ctrl_strobe = wr & d[pos];
	endfunction

	// Control state
	lio_pkg::lio_fault_s flt_r, flt_nxt;
	logic [1:0] mode_r, mode_nxt;
	logic ext_cnt_r, ext_cnt_nxt;
	logic nonstop_r, nonstop_nxt;
	logic dispense_r, dispense_nxt;
	logic run_r, run_nxt;
	logic warn_r, warn_nxt;
	logic err_r, err_nxt;
	logic [6:0] spacing_r, spacing_nxt;
	logic spacing_bad_r, spacing_bad_nxt;
	logic [31:0] goods_r, goods_nxt;
	logic [31:0] pulses_r, pulses_nxt;
	logic [31:0] timer_r, timer_nxt;
	logic [31:0] interval_r, interval_nxt;
	lio_pkg::lio_meas_state_e ms_r, ms_nxt;
	logic [31:0] rdata_r, rdata_nxt;

	logic any_fault, healthy, label_ok, wr_ctrl, wr_spc, run_key;
	logic [31:0] wd;
	logic [31:0] status;
	logic confirm, warn_set, err_set, arm_meas;
	logic pin_healthy, pin_motion;

	assign wd = hwdata;
	assign any_fault = |flt_r;
	assign healthy = ~any_fault & supply_ok; // RL2 RL3
	assign label_ok = run_r & healthy & ~busy; // RL6
	assign wr_ctrl = wr_en & (addr == lio_pkg::REG_CTRL);
	assign wr_spc = wr_en & (addr == lio_pkg::REG_SPACING);
	// Write-only strobes; reading CTRL never shows them
	assign run_key = ctrl_strobe(wr_ctrl, wd, lio_pkg::CTRL_RUNKEY);
	assign confirm = ctrl_strobe(wr_ctrl, wd, lio_pkg::CTRL_CONFIRM);
	assign warn_set = ctrl_strobe(wr_ctrl, wd, lio_pkg::CTRL_WARN_SET);
	assign err_set = ctrl_strobe(wr_ctrl, wd, lio_pkg::CTRL_ERR_SET);
	assign arm_meas = ctrl_strobe(wr_ctrl, wd, lio_pkg::CTRL_ARM_MEAS);
	// A fault seen this cycle drops the healthy and motor pins at once, not after latching
	assign pin_healthy = healthy & ~(|flt_now);
	assign pin_motion = label_ok & dispense_r;

	// Live view; relay and fault flag pins match it in step, the motion pin one cycle later
	assign status = {19'h00000, label_ok & dispense_r, label_ok,
		spacing_bad_r, (ms_r == lio_pkg::LIO_MS_DONE), err_r, warn_r,
		busy, run_r, healthy, flt_r};

	always_comb begin
		flt_nxt = flt_r;
		mode_nxt = mode_r;
		ext_cnt_nxt = ext_cnt_r;
		nonstop_nxt = nonstop_r;
		dispense_nxt = dispense_r;
		run_nxt = run_r;
		warn_nxt = warn_r;
		err_nxt = err_r;
		spacing_nxt = spacing_r;
		spacing_bad_nxt = spacing_bad_r;
		goods_nxt = goods_r;
		pulses_nxt = pulses_r;
		timer_nxt = timer_r;
		interval_nxt = interval_r;
		ms_nxt = ms_r;
		rdata_nxt = rdata_r;
		if (ce) begin
			// Only hresetn clears these; no bus write reaches them
			flt_nxt = flt_r | flt_now; // RL1 RL4
			if (wr_ctrl) begin
				mode_nxt = wd[lio_pkg::CTRL_MODE_LSB +: 2];
				ext_cnt_nxt = wd[lio_pkg::CTRL_EXT_CNT];
				nonstop_nxt = wd[lio_pkg::CTRL_NONSTOP];
				dispense_nxt = wd[lio_pkg::CTRL_DISPENSE];
			end
			// Toggle touches run only; counter and messages untouched
			if (stop_rise ^ run_key) begin
				run_nxt = ~run_r; // RL14 RL16 RL17
			end
			// Confirm clears only once the cause has gone; set wins
			if (confirm & ~busy) begin
				warn_nxt = 1'b0; // RL20
			end
			if (confirm & ~any_fault) begin
				err_nxt = 1'b0; // RL20
			end
			if (busy & run_r) begin
				warn_nxt = 1'b1; // RL6
			end
			if (warn_set) begin
				warn_nxt = 1'b1;
			end
			if (any_fault | err_set) begin
				err_nxt = 1'b1; // RL4
			end
			// A rejected value keeps the old spacing; only the flag tells
			if (wr_spc) begin
				if (wd >= 32'(lio_pkg::SPACING_MIN_MM) &&
					wd <= 32'(lio_pkg::SPACING_MAX_MM)) begin
					spacing_nxt = wd[6:0]; // RL10
					spacing_bad_nxt = 1'b0;
				end else begin
					spacing_bad_nxt = 1'b1; // RL10
				end
			end
			// Scanner counts goods unless the count input is the source
			if ((nonstop_r | ext_cnt_r) ? count_rise : goods_rise) begin
				goods_nxt = goods_r + 32'h00000001; // RL8 RL13
			end
			if (mode_r == lio_pkg::LIO_SPD_INCR && speed_rise) begin
				pulses_nxt = sat_inc(pulses_r); // RL12
			end
			if (mode_r == lio_pkg::LIO_SPD_MEASURE) begin
				case (ms_r) // RL11
				lio_pkg::LIO_MS_IDLE: begin
					if (speed_rise) begin
						timer_nxt = 32'h00000000;
						ms_nxt = lio_pkg::LIO_MS_TIMING;
					end
				end
				lio_pkg::LIO_MS_TIMING: begin
					// Saturates so a missed goods edge never wraps short
					timer_nxt = sat_inc(timer_r);
					if (goods_rise) begin
						interval_nxt = timer_r;
						ms_nxt = lio_pkg::LIO_MS_DONE;
					end
				end
				lio_pkg::LIO_MS_DONE: begin
					if (arm_meas) begin
						ms_nxt = lio_pkg::LIO_MS_IDLE;
					end
				end
				default: ms_nxt = lio_pkg::LIO_MS_IDLE;
				endcase
			end else begin
				ms_nxt = lio_pkg::LIO_MS_IDLE; // RL9
			end
			// Captured on the address phase; held until the next read
			if (rd_en) begin
				case (addr)
				lio_pkg::REG_CTRL: rdata_nxt = {27'h0000000, dispense_r,
					nonstop_r, ext_cnt_r, mode_r};
				lio_pkg::REG_STATUS: rdata_nxt = status;
				lio_pkg::REG_SPACING: rdata_nxt = {25'h0000000, spacing_r};
				lio_pkg::REG_INTERVAL: rdata_nxt = interval_r;
				lio_pkg::REG_PULSES: rdata_nxt = pulses_r;
				lio_pkg::REG_GOODS: rdata_nxt = goods_r;
				lio_pkg::REG_MSG: rdata_nxt = {30'h00000000, err_r, warn_r};
				default: rdata_nxt = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flt_r <= '0;
			mode_r <= 2'h0;
			ext_cnt_r <= 1'b0;
			nonstop_r <= 1'b0;
			dispense_r <= 1'b0;
			run_r <= 1'b0;
			warn_r <= 1'b0;
			err_r <= 1'b0;
			spacing_r <= lio_pkg::SPACING_RST;
			spacing_bad_r <= 1'b0;
			goods_r <= 32'h00000000;
			pulses_r <= 32'h00000000;
			timer_r <= 32'h00000000;
			interval_r <= 32'h00000000;
			ms_r <= lio_pkg::LIO_MS_IDLE;
			rdata_r <= 32'h00000000;
		end else begin
			flt_r <= flt_nxt;
			mode_r <= mode_nxt;
			ext_cnt_r <= ext_cnt_nxt;
			nonstop_r <= nonstop_nxt;
			dispense_r <= dispense_nxt;
			run_r <= run_nxt;
			warn_r <= warn_nxt;
			err_r <= err_nxt;
			spacing_r <= spacing_nxt;
			spacing_bad_r <= spacing_bad_nxt;
			goods_r <= goods_nxt;
			pulses_r <= pulses_nxt;
			timer_r <= timer_nxt;
			interval_r <= interval_nxt;
			ms_r <= ms_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Pin outputs: registered, taken from next-state values and live fault lines, except motion from current state
	logic [9:0] pins_r, pins_nxt;
	always_comb begin
		pins_nxt = pins_r;
		if (ce) begin
			pins_nxt = {err_nxt, warn_nxt, run_nxt, // RL15
				pin_motion, // RL5
				pin_healthy, // RL3
				pin_healthy, // RL2
				flt_nxt};
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pins_r <= 10'h000;
		end else begin
			pins_r <= pins_nxt;
		end
	end

	assign hrdata = rdata_r;
	assign {error_relay_out, warning_relay_out, run_relay_out,
		motion_out, motor_enable, driver_healthy_flag} = pins_r[9:4];
	assign phase_short_flag = pins_r[3];
	assign overtemp_flag = pins_r[2];
	assign overvoltage_flag = pins_r[1];
	assign undervoltage_flag = pins_r[0];
endmodule
`default_nettype wire

// file: bench/lio_checker.sv
// Concurrent checks on the lio_top ports, bound into every instance.
// Assumes one clock domain and ce high whenever a fault line moves.
`timescale 1ns/1ps
`default_nettype none
module lio_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic drv_short_n,
	input wire logic drv_overtemp_n,
	input wire logic drv_supply_ok_n,
	input wire logic periph_ready_in_n,
	input wire logic ext_stop_in_n,
	input wire logic driver_healthy_flag,
	input wire logic phase_short_flag,
	input wire logic overtemp_flag,
	input wire logic overvoltage_flag,
	input wire logic undervoltage_flag,
	input wire logic motor_enable,
	input wire logic motion_out,
	input wire logic run_relay_out,
	input wire logic error_relay_out
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire logic [3:0] flt = {phase_short_flag, overtemp_flag,
		overvoltage_flag, undervoltage_flag};
	short_flag_a: assert property (
		!drv_short_n [*3] |-> ##[1:5] phase_short_flag)
		else $error("short flag missing");
	temp_flag_a: assert property (
		!drv_overtemp_n [*3] |-> ##[1:5] overtemp_flag)
		else $error("overtemp flag missing");
	flag_latch_a: assert property (
		flt != 4'h0 |=> (flt & $past(flt)) == $past(flt))
		else $error("fault flag dropped");
	fault_drop_a: assert property (
		flt != 4'h0 |=> !driver_healthy_flag && !motor_enable)
		else $error("motor live with fault");
	motor_health_a: assert property (
		motor_enable == driver_healthy_flag)
		else $error("motor enable differs from healthy");
	supply_health_a: assert property (
		drv_supply_ok_n [*4] |-> !driver_healthy_flag)
		else $error("healthy without supply");
	motion_start_a: assert property (
		$rose(motion_out) |-> run_relay_out && driver_healthy_flag)
		else $error("motion without run");
	busy_block_a: assert property (
		!periph_ready_in_n [*6] |-> !motion_out)
		else $error("motion while busy");
	stop_level_a: assert property (
		!ext_stop_in_n [*8] |=> $stable(run_relay_out))
		else $error("held stop toggled run");
	fault_report_a: assert property (
		flt != 4'h0 |-> ##3 error_relay_out)
		else $error("fault not reported");
	motion_c: cover property ($rose(motion_out));
	run_c: cover property ($rose(run_relay_out));
	err_c: cover property ($rose(error_relay_out));
endmodule
bind lio_top lio_checker chk_u (.*);
`default_nettype wire

// file: bench/lio_field.sv
// Field-side model: driver lines, scanners and an encoder, open collector.
// Assumes pull-ups on every line; the bench says which lines are active.
`timescale 1ns/1ps
`default_nettype none
module lio_field (
	input wire logic hclk,
	input wire logic [9:0] act,
	input wire logic enc,
	output logic [9:0] line_n
);
	logic [2:0] ph = 3'h0;
	// Encoder pitch of eight clocks, half active, so the sync sees each edge
	always @(posedge hclk) begin
		ph <= enc ? ph + 3'h1 : 3'h0;
	end
	// Released lines float up to the pull-up, never to the last value
	assign line_n = ~(act | {4'h0, enc & ph[2], 5'h0});
endmodule
`default_nettype wire

// file: bench/tb.sv
// Bench for lio_top: AHB-Lite word tasks and field-line scenarios.
// Assumes lio_field on the sensor side and the bound lio_checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [9:0] act = 10'h010;
	logic enc = 1'b0;
	logic ce = 1'b1;
	logic [31:0] q;
	logic [31:0] p;
	int fail_count = 0;
	int checks = 0;
	wire logic hready;
	wire logic hresp;
	wire logic [31:0] hrdata;
	wire logic [9:0] ln;
	wire logic [3:0] flt;
	wire logic healthy, motor, motion, run, warn, err;
	logic [31:0] sv [4] = '{32'h9, 32'h64, 32'h65, 32'hA};
	logic [31:0] se [4] = '{32'h32, 32'h64, 32'h64, 32'hA};
	logic [31:0] cv [3] = '{32'h14, 32'h18, 32'h10};
	always #12.5 hclk = ~hclk;
	lio_field fld_u (.hclk(hclk), .act(act), .enc(enc), .line_n(ln));
	lio_top dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
		.hrdata(hrdata), .drv_short_n(ln[0]), .drv_overtemp_n(ln[1]),
		.drv_overvolt_n(ln[2]), .drv_undervolt_n(ln[3]),
		.drv_supply_ok_n(ln[4]), .speed_scanner_in_n(ln[5]),
		.goods_scanner_in_n(ln[6]), .goods_count_in_n(ln[7]),
		.ext_stop_in_n(ln[8]), .periph_ready_in_n(ln[9]),
		.driver_healthy_flag(healthy), .phase_short_flag(flt[3]),
		.overtemp_flag(flt[2]), .overvoltage_flag(flt[1]),
		.undervoltage_flag(flt[0]), .motor_enable(motor),
		.motion_out(motion), .run_relay_out(run),
		.warning_relay_out(warn), .error_relay_out(err));
	task automatic report_and_stop;
		if (fail_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic pin(input logic v, input logic e);
		chk({31'h0, v}, {31'h0, e});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// Bounded wait for hready; a stuck bus ends the run
	task automatic hold;
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1 && n < 50) begin
			@(posedge hclk);
			n++;
		end
		if (n >= 50) begin
			fail_count++;
			report_and_stop;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		hold;
		htrans <= 2'h0;
		hwdata <= d;
		hold;
		q = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q & m, e);
		pin(hresp, 1'b0);
	endtask
	task automatic pulse(input int i);
		act[i] <= 1'b1;
		cyc(10);
		act[i] <= 1'b0;
		cyc(10);
	endtask
	task automatic power_cycle;
		hresetn <= 1'b0;
		cyc(12);
		hresetn <= 1'b1;
	endtask
	initial begin
		cyc(12);
		hresetn <= 1'b1;
		cyc(8);
		pin(healthy, 1'b1);
		pin(motor, 1'b1);
		act[4] <= 1'b0;
		cyc(8);
		pin(healthy, 1'b0);
		act[4] <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, lio_pkg::REG_CTRL, cv[i]);
			pulse(7);
		end
		rd(lio_pkg::REG_GOODS, 32'hFFFFFFFF, 32'h2);
		bus(1'b1, lio_pkg::REG_CTRL, 32'h18);
		pulse(8);
		pin(run, 1'b1);
		pin(motion, 1'b1);
		rd(lio_pkg::REG_STATUS, 32'h20, 32'h20);
		pulse(7);
		pulse(8);
		pin(run, 1'b0);
		pin(motion, 1'b0);
		pulse(7);
		rd(lio_pkg::REG_GOODS, 32'hFFFFFFFF, 32'h4);
		ce <= 1'b0;
		pulse(8);
		ce <= 1'b1;
		cyc(4);
		pin(run, 1'b0);
		bus(1'b1, lio_pkg::REG_CTRL, 32'h10);
		pulse(6);
		rd(lio_pkg::REG_GOODS, 32'hFFFFFFFF, 32'h5);
		pulse(8);
		act[9] <= 1'b1;
		cyc(10);
		pin(motion, 1'b0);
		pin(warn, 1'b1);
		rd(lio_pkg::REG_STATUS, 32'h40, 32'h40);
		pulse(8);
		pin(warn, 1'b1);
		act[9] <= 1'b0;
		cyc(8);
		pin(warn, 1'b1);
		bus(1'b1, lio_pkg::REG_CTRL, 32'h58);
		cyc(4);
		pin(warn, 1'b0);
		bus(1'b1, lio_pkg::REG_CTRL, 32'h38);
		cyc(4);
		pin(run, 1'b1);
		bus(1'b1, lio_pkg::REG_CTRL, 32'h1B8);
		cyc(4);
		pin(run, 1'b0);
		pin(warn, 1'b1);
		pin(err, 1'b1);
		bus(1'b1, lio_pkg::REG_CTRL, 32'h58);
		cyc(4);
		pin(err, 1'b0);
		pin(warn, 1'b0);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, lio_pkg::REG_SPACING, sv[i]);
			rd(lio_pkg::REG_SPACING, 32'hFFFFFFFF, se[i]);
			if (i == 0) rd(lio_pkg::REG_STATUS, 32'h400, 32'h400);
		end
		bus(1'b1, lio_pkg::REG_CTRL, 32'h219);
		act[5] <= 1'b1;
		cyc(20);
		act[6] <= 1'b1;
		cyc(10);
		act[6:5] <= 2'h0;
		cyc(8);
		bus(1'b0, lio_pkg::REG_INTERVAL, 32'h0);
		chk({31'h0, q >= 32'h13 && q <= 32'h15}, 32'h1);
		rd(lio_pkg::REG_STATUS, 32'h200, 32'h200);
		bus(1'b1, lio_pkg::REG_CTRL, 32'h18);
		bus(1'b0, lio_pkg::REG_PULSES, 32'h0);
		p = q;
		pulse(5);
		pulse(5);
		rd(lio_pkg::REG_PULSES, 32'hFFFFFFFF, p);
		bus(1'b1, lio_pkg::REG_CTRL, 32'h1A);
		bus(1'b0, lio_pkg::REG_PULSES, 32'h0);
		p = q + 32'h5;
		enc <= 1'b1;
		cyc(40);
		enc <= 1'b0;
		cyc(8);
		rd(lio_pkg::REG_PULSES, 32'hFFFFFFFF, p);
		for (int i = 0; i < 4; i++) begin
			power_cycle;
			act[i] <= 1'b1;
			cyc(10);
			chk({28'h0, flt}, 32'h8 >> i);
			pin(healthy, 1'b0);
			pin(motor, 1'b0);
			act[i] <= 1'b0;
			bus(1'b1, lio_pkg::REG_CTRL, 32'h40);
			cyc(8);
			pin(err, 1'b1);
			rd(lio_pkg::REG_STATUS, 32'hF, 32'h8 >> i);
		end
		power_cycle;
		cyc(2);
		chk({28'h0, flt}, 32'h0);
		report_and_stop;
	end
endmodule
`default_nettype wire
